// File: logic/gsfm_pkg.sv
// Package: constants and carrier types for the pin-function multiplexer
package gsfm_pkg;
	localparam int GSFM_NPINS    = 10;
	localparam int GSFM_PIN_XO   = 0;
	localparam int GSFM_PIN_REF  = 3;
	localparam int GSFM_PIN_DAT  = 4;
	localparam int GSFM_PIN_LED  = 5;
	localparam int GSFM_PIN_CK6  = 6;
	localparam int GSFM_SEL_P4   = 0;
	localparam int GSFM_SEL_P6   = 1;
	localparam int GSFM_SMALL_PINS = 7;
	localparam logic [1:0] GSFM_LED_OFF = 2'h0;
	localparam logic [9:0] GSFM_VAL_RST = 10'h0_1df;
	localparam logic [9:0] GSFM_CFG_RST = 10'h0_000;

	// Roles a pin can take
	typedef enum logic [2:0] {
		GSFM_ROLE_GPIO,
		GSFM_ROLE_VPP,
		GSFM_ROLE_XO,
		GSFM_ROLE_REF,
		GSFM_ROLE_DBG,
		GSFM_ROLE_CLKO,
		GSFM_ROLE_LED
	} gsfm_role_t;

	// Software controls
	typedef struct packed {
		logic [9:0] port_value;
		logic [9:0] port_drive_config;
		logic       crystal_osc_enable;
		logic       ref_clock_route_enable;
		logic       clock_output_enable;
		logic [1:0] clock_output_pin_select;
		logic [1:0] led_current_level;
		logic [1:0] matrix_roff;
		logic       large_package;
	} gsfm_ctrl_t;

	// Debug adapter side
	typedef struct packed {
		logic session_active;
		logic transaction_active;
		logic led_disable;
		logic led_disable_override;
		logic data_out;
		logic data_oe;
	} gsfm_dbg_t;

	// Pad drive for every pin
	typedef struct packed {
		logic [9:0] out;
		logic [9:0] oe;
	} gsfm_pad_t;
endpackage

// File: logic/gsfm_pin_role.sv
// Per-pin role arbiter by fixed priority
`timescale 1ns/1ps
module gsfm_pin_role (
	input  wire logic               i_vpp_mode,
	input  wire gsfm_pkg::gsfm_ctrl_t i_ctrl,
	input  wire gsfm_pkg::gsfm_dbg_t  i_dbg,
	input  wire logic               i_led_on,
	output gsfm_pkg::gsfm_role_t    o_role [gsfm_pkg::GSFM_NPINS]
);
	import gsfm_pkg::*;

	genvar g;
	generate
		for (g = 0; g < GSFM_NPINS; g++) begin : g_pin
			always_comb begin
				o_role[g] = GSFM_ROLE_GPIO;
				if (g == GSFM_PIN_XO) begin
					if (i_vpp_mode) begin
						o_role[g] = GSFM_ROLE_VPP;
					end else if (i_ctrl.crystal_osc_enable) begin
						o_role[g] = GSFM_ROLE_XO;
					end
				end else if (g == GSFM_PIN_REF) begin
					if (i_ctrl.ref_clock_route_enable) begin
						o_role[g] = GSFM_ROLE_REF;
					end
				end else if (g == GSFM_PIN_DAT) begin
					if (i_dbg.transaction_active) begin
						o_role[g] = GSFM_ROLE_DBG;
					end else if (i_ctrl.clock_output_enable
						&& i_ctrl.clock_output_pin_select[GSFM_SEL_P4]) begin
						o_role[g] = GSFM_ROLE_CLKO;
					end
				end else if (g == GSFM_PIN_LED) begin
					if (!i_led_on) begin
						o_role[g] = GSFM_ROLE_DBG;
					end else begin
						o_role[g] = GSFM_ROLE_LED;
					end
				end else if (g == GSFM_PIN_CK6) begin
					if (i_ctrl.clock_output_enable
						&& i_ctrl.clock_output_pin_select[GSFM_SEL_P6]) begin
						o_role[g] = GSFM_ROLE_CLKO;
					end
				end
			end
		end
	endgenerate
endmodule

// File: logic/gsfm_mux.sv
// Pin-function multiplexer with LED driver and debug takeover
`timescale 1ns/1ps
// Function
// - Each pin takes the highest-priority selected role; lower ones ignored
// - Pin 0: programming voltage, then crystal input, else input-only port
// - Pin 3 routes reference clock to counter when route enable set
// - Pin 4 becomes debug data during every debug transaction
// - Pin 4 outputs customer clock when enable and select bit 0 set
// - Pin 5 is debug clock input whenever LED driver is off
// - LED role forces pin 5 output; real drive state on status bit
// - Customer clock selectable on pin 4, pin 6, or both independently
// - LED current has three levels chosen by a two-bit field
// - Port bit 5 switches LED; pin 5 driven high (push-pull) while LED on
// - LED on disables pin 5 pull-down transistor
// - Pin 5 is plain open-drain output only during debug session
// - Debugger disables LED in session unless override given
// - Writes to port bit 0 have no effect
// - Port bit 5 reads zero while LED current level is zero
module gsfm_mux (
	input  wire logic                 i_clk,
	input  wire logic                 i_resetn,
	input  wire logic                 i_vpp_mode,
	input  wire gsfm_pkg::gsfm_ctrl_t i_ctrl,
	input  wire gsfm_pkg::gsfm_dbg_t  i_dbg,
	input  wire logic                 i_customer_clk,
	input  wire logic [9:0]           i_pad_in,
	output gsfm_pkg::gsfm_pad_t       o_pad,
	output logic [9:0]                o_port_read,
	output logic                      o_led_drive_status,
	output logic [1:0]                o_led_current_level,
	output logic                      o_led_pulldown_disable,
	output logic                      o_xo_in,
	output logic                      o_ref_clk,
	output logic                      o_debug_clock_pin,
	output logic                      o_debug_data_pin,
	output logic [2:0]                o_matrix_roff_pins,
	output logic [1:0]                o_matrix_roff
);
	import gsfm_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Reset synchroniser
	logic [1:0] rst_sync_r;
	logic       rst_n;

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[1];

	////////////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		gsfm_pad_t  pad;
		logic [9:0] read;
		logic       led_drive;
		logic [1:0] led_level;
		logic       pd_dis;
		logic       xo_in;
		logic       ref_clk;
		logic       dbg_clk;
		logic       dbg_dat;
		logic [1:0] roff;
	} gsfm_state_t;

	gsfm_state_t st_r;
	gsfm_state_t st_nxt;
	gsfm_role_t  role [GSFM_NPINS];
	logic        led_on;
	logic        led_want;
	logic        led_blocked;
	logic [9:0]  present;

	// Port bit 5 request, qualified by a nonzero level
	assign led_want = i_ctrl.port_value[GSFM_PIN_LED]
		&& (i_ctrl.led_current_level != GSFM_LED_OFF);
	// Debug disable wins unless overridden
	assign led_blocked = i_dbg.session_active && i_dbg.led_disable
		&& !i_dbg.led_disable_override;
	assign led_on = led_want && !led_blocked;
	assign present = i_ctrl.large_package ? 10'h3_ff : 10'h0_7f;

	gsfm_pin_role u_role (
		.i_vpp_mode (i_vpp_mode),
		.i_ctrl     (i_ctrl),
		.i_dbg      (i_dbg),
		.i_led_on   (led_on),
		.o_role     (role)
	);

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		st_nxt = st_r;
		for (int p = 0; p < GSFM_NPINS; p++) begin
			// Plain port: open drain drives only low, push-pull drives both
			st_nxt.pad.out[p] = i_ctrl.port_value[p];
			st_nxt.pad.oe[p]  = present[p] && (i_ctrl.port_drive_config[p]
				|| !i_ctrl.port_value[p]);
			st_nxt.read[p]    = present[p] && i_pad_in[p];
			unique case (role[p])
				GSFM_ROLE_VPP, GSFM_ROLE_XO, GSFM_ROLE_REF: begin
					st_nxt.pad.out[p] = 1'b0;
					st_nxt.pad.oe[p]  = 1'b0;
				end
				GSFM_ROLE_CLKO: begin
					st_nxt.pad.out[p] = i_customer_clk;
					st_nxt.pad.oe[p]  = 1'b1;
				end
				GSFM_ROLE_DBG: begin
					if (p == GSFM_PIN_DAT) begin
						st_nxt.pad.out[p] = i_dbg.data_out;
						st_nxt.pad.oe[p]  = i_dbg.data_oe;
					end else begin
						// Open drain in session only, else input
						st_nxt.pad.out[p] = 1'b0;
						st_nxt.pad.oe[p]  = i_dbg.session_active
							&& !i_ctrl.port_value[p];
					end
				end
				GSFM_ROLE_LED: begin
					st_nxt.pad.out[p] = 1'b1;
					st_nxt.pad.oe[p]  = 1'b1;
				end
				default: begin
				end
			endcase
		end
		// Pin 0 never drives
		st_nxt.pad.out[GSFM_PIN_XO] = 1'b0;
		st_nxt.pad.oe[GSFM_PIN_XO]  = 1'b0;
		st_nxt.read[GSFM_PIN_LED] = led_want;
		st_nxt.led_drive = led_on;
		st_nxt.led_level = led_on ? i_ctrl.led_current_level : GSFM_LED_OFF;
		st_nxt.pd_dis    = led_on;
		st_nxt.xo_in     = (role[GSFM_PIN_XO] == GSFM_ROLE_XO) && i_pad_in[GSFM_PIN_XO];
		st_nxt.ref_clk   = (role[GSFM_PIN_REF] == GSFM_ROLE_REF)
			&& i_pad_in[GSFM_PIN_REF];
		st_nxt.dbg_clk   = (role[GSFM_PIN_LED] == GSFM_ROLE_DBG)
			&& i_pad_in[GSFM_PIN_LED];
		st_nxt.dbg_dat   = i_pad_in[GSFM_PIN_DAT];
		st_nxt.roff      = i_ctrl.matrix_roff;
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign o_pad                  = st_r.pad;
	assign o_port_read            = st_r.read;
	assign o_led_drive_status     = st_r.led_drive;
	assign o_led_current_level    = st_r.led_level;
	assign o_led_pulldown_disable = st_r.pd_dis;
	assign o_xo_in                = st_r.xo_in;
	assign o_ref_clk              = st_r.ref_clk;
	assign o_debug_clock_pin      = st_r.dbg_clk;
	assign o_debug_data_pin       = st_r.dbg_dat;
	// Pad option latch controls
	assign o_matrix_roff_pins     = {3{1'b1}};
	assign o_matrix_roff          = st_r.roff;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_led_req;
		led_on;
	endsequence

	a_led_status: assert property (@(posedge i_clk) disable iff (!rst_n)
		s_led_req |=> o_led_drive_status && o_pad.oe[GSFM_PIN_LED])
		else $error("LED status or drive missing");
	a_led_pulldown: assert property (@(posedge i_clk) disable iff (!rst_n)
		o_led_pulldown_disable == o_led_drive_status)
		else $error("Pull-down not disabled with LED");
	a_led_disable: assert property (@(posedge i_clk) disable iff (!rst_n)
		led_blocked |=> !o_led_drive_status)
		else $error("LED driven during debug disable");
	a_pin0_quiet: assert property (@(posedge i_clk) disable iff (!rst_n)
		!o_pad.oe[GSFM_PIN_XO])
		else $error("Pin 0 driven");
	a_readback_zero: assert property (@(posedge i_clk) disable iff (!rst_n)
		(i_ctrl.led_current_level == GSFM_LED_OFF) |=> !o_port_read[GSFM_PIN_LED])
		else $error("Port bit 5 read nonzero at level zero");
	a_dbg_data: assert property (@(posedge i_clk) disable iff (!rst_n)
		i_dbg.transaction_active |=> (o_pad.oe[GSFM_PIN_DAT] == $past(i_dbg.data_oe)))
		else $error("Debug data not on pin 4");
	a_ref_route: assert property (@(posedge i_clk) disable iff (!rst_n)
		i_ctrl.ref_clock_route_enable |=> !o_pad.oe[GSFM_PIN_REF])
		else $error("Pin 3 driven while routed to counter");
	a_clk_out6: assert property (@(posedge i_clk) disable iff (!rst_n)
		(i_ctrl.clock_output_enable && i_ctrl.clock_output_pin_select[GSFM_SEL_P6]
			&& i_ctrl.large_package)
		|=> o_pad.oe[GSFM_PIN_CK6])
		else $error("Clock output missing on pin 6");
	a_xo_input: assert property (@(posedge i_clk) disable iff (!rst_n)
		(i_vpp_mode || i_ctrl.crystal_osc_enable) |=> !o_pad.oe[GSFM_PIN_XO])
		else $error("Pin 0 special role driven");

	////////////////////////////////////////////////////////////////////////////
	// Role checks
	sequence s_vpp_on;
		i_vpp_mode;
	endsequence
	sequence s_xo_sel;
		!i_vpp_mode && i_ctrl.crystal_osc_enable;
	endsequence
	sequence s_ref_sel;
		i_ctrl.ref_clock_route_enable;
	endsequence
	sequence s_txn;
		i_dbg.transaction_active;
	endsequence
	sequence s_clk4_sel;
		!i_dbg.transaction_active && i_ctrl.clock_output_enable
			&& i_ctrl.clock_output_pin_select[GSFM_SEL_P4];
	endsequence
	sequence s_clk6_sel;
		i_ctrl.clock_output_enable && i_ctrl.clock_output_pin_select[GSFM_SEL_P6];
	endsequence
	sequence s_led_off;
		!led_on;
	endsequence
	sequence s_pin5_dbg;
		!led_on && i_dbg.session_active;
	endsequence
	sequence s_pin5_app;
		!led_on && !i_dbg.session_active;
	endsequence

	a_vpp_first: assert property (@(posedge i_clk) disable iff (!rst_n)
		s_vpp_on |=> !o_xo_in && !o_pad.oe[GSFM_PIN_XO])
		else $error("Crystal input live under programming voltage");
	a_xo_follow: assert property (@(posedge i_clk) disable iff (!rst_n)
		s_xo_sel |=> (o_xo_in == $past(i_pad_in[GSFM_PIN_XO])))
		else $error("Crystal input not taken from pin 0");
	a_xo_idle: assert property (@(posedge i_clk) disable iff (!rst_n)
		!i_ctrl.crystal_osc_enable |=> !o_xo_in)
		else $error("Crystal input live while disabled");
	a_ref_follow: assert property (@(posedge i_clk) disable iff (!rst_n)
		s_ref_sel |=> (o_ref_clk == $past(i_pad_in[GSFM_PIN_REF])))
		else $error("Reference clock not taken from pin 3");
	a_ref_idle: assert property (@(posedge i_clk) disable iff (!rst_n)
		!i_ctrl.ref_clock_route_enable |=> !o_ref_clk)
		else $error("Reference clock live while route disabled");
	a_dbg_dat_out: assert property (@(posedge i_clk) disable iff (!rst_n)
		s_txn |=> (o_pad.out[GSFM_PIN_DAT] == $past(i_dbg.data_out)))
		else $error("Debug data value not on pin 4");
	a_dbg_dat_in: assert property (@(posedge i_clk) disable iff (!rst_n)
		1'b1 |=> (o_debug_data_pin == $past(i_pad_in[GSFM_PIN_DAT])))
		else $error("Debug data input not taken from pin 4");
	a_clk_out4: assert property (@(posedge i_clk) disable iff (!rst_n)
		s_clk4_sel |=> o_pad.oe[GSFM_PIN_DAT]
			&& (o_pad.out[GSFM_PIN_DAT] == $past(i_customer_clk)))
		else $error("Clock output missing on pin 4");
	a_clk_val6: assert property (@(posedge i_clk) disable iff (!rst_n)
		s_clk6_sel |=> (o_pad.out[GSFM_PIN_CK6] == $past(i_customer_clk)))
		else $error("Clock value wrong on pin 6");
	a_dbg_clk: assert property (@(posedge i_clk) disable iff (!rst_n)
		s_led_off |=> (o_debug_clock_pin == $past(i_pad_in[GSFM_PIN_LED])))
		else $error("Debug clock not taken from pin 5");
	a_led_dark: assert property (@(posedge i_clk) disable iff (!rst_n)
		s_led_off |=> !o_led_drive_status && (o_led_current_level == GSFM_LED_OFF))
		else $error("LED level shown while LED off");
	a_led_level: assert property (@(posedge i_clk) disable iff (!rst_n)
		s_led_req |=> (o_led_current_level == $past(i_ctrl.led_current_level)))
		else $error("LED level not applied");
	a_led_switch: assert property (@(posedge i_clk) disable iff (!rst_n)
		!i_ctrl.port_value[GSFM_PIN_LED] |=> !o_led_drive_status)
		else $error("LED on with port bit 5 low");
	a_pin5_app: assert property (@(posedge i_clk) disable iff (!rst_n)
		s_pin5_app |=> !o_pad.oe[GSFM_PIN_LED])
		else $error("Pin 5 driven outside debug session");
	a_pin5_od: assert property (@(posedge i_clk) disable iff (!rst_n)
		s_pin5_dbg |=> !o_pad.out[GSFM_PIN_LED]
			&& (o_pad.oe[GSFM_PIN_LED] == !$past(i_ctrl.port_value[GSFM_PIN_LED])))
		else $error("Pin 5 not open drain in session");
	a_led_readback: assert property (@(posedge i_clk) disable iff (!rst_n)
		(i_ctrl.port_value[GSFM_PIN_LED]
			&& (i_ctrl.led_current_level != GSFM_LED_OFF))
		|=> o_port_read[GSFM_PIN_LED])
		else $error("Port bit 5 reads zero while requested");
	a_absent_pins: assert property (@(posedge i_clk) disable iff (!rst_n)
		!i_ctrl.large_package
		|=> (o_pad.oe[9:7] == 3'h0) && (o_port_read[9:7] == 3'h0))
		else $error("Absent pins active on small package");
	a_push_pull: assert property (@(posedge i_clk) disable iff (!rst_n)
		(i_ctrl.port_drive_config[2:1] == 2'h3)
		|=> (o_pad.oe[2:1] == 2'h3)
			&& (o_pad.out[2:1] == $past(i_ctrl.port_value[2:1])))
		else $error("Push-pull pins 1 and 2 not driven");
	a_roff_pass: assert property (@(posedge i_clk) disable iff (!rst_n)
		1'b1 |=> (o_matrix_roff == $past(i_ctrl.matrix_roff)))
		else $error("Matrix and pull-up options not passed on");
endmodule

// File: verif/gsfm_far_model.sv
// Buttons, LED wire and debug adapter beyond the pins
`timescale 1ns/1ps
module gsfm_far_model (
	input  wire logic                i_clk,
	input  wire gsfm_pkg::gsfm_pad_t i_pad,
	input  wire logic [9:0]          i_btn_n,
	input  wire logic                i_connect,
	input  wire logic                i_override,
	input  wire logic                i_txn,
	input  wire logic                i_dout,
	input  wire logic                i_led_lit,
	output logic [9:0]               o_pad_in,
	output gsfm_pkg::gsfm_dbg_t      o_dbg
);
	import gsfm_pkg::*;
	logic sess_r = 1'b0;
	// Driven level wins, else pull-up or pressed button
	assign o_pad_in = (i_pad.oe & i_pad.out) | (~i_pad.oe & i_btn_n);
	// Attach only while the LED is dark
	always_ff @(posedge i_clk) begin
		if (!i_connect)
			sess_r <= 1'b0;
		else if (!i_led_lit)
			sess_r <= 1'b1;
	end
	assign o_dbg = '{session_active: sess_r, transaction_active: sess_r & i_txn,
		led_disable: sess_r, led_disable_override: i_override,
		data_out: i_dout, data_oe: sess_r & i_txn};
endmodule

// File: verif/tb_gsfm_mux.sv
// Self-checking bench for the pin-function multiplexer
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; \
	$display("[ERR] %0t mismatch %b vs %b", $time, (a), (b)); end end
module tb_gsfm_mux;
	import gsfm_pkg::*;
	logic       clk = 1'b0;
	logic       resetn = 1'b0;
	logic       vpp = 1'b0;
	logic       cclk = 1'b0;
	logic       conn = 1'b0;
	logic       ovr = 1'b0;
	logic       txn = 1'b0;
	logic       dout = 1'b0;
	logic [9:0] btn_n = 10'h3_ff;
	gsfm_ctrl_t ctrl = '0;
	gsfm_ctrl_t c;
	gsfm_dbg_t  dbg;
	gsfm_pad_t  pad;
	logic [9:0] pin;
	logic [9:0] prd;
	logic       lst;
	logic       lpd;
	logic       xo;
	logic       rck;
	logic       dck;
	logic       ddat;
	logic [1:0] llev;
	logic [1:0] mr;
	logic [2:0] mrp;
	int         n_mismatch = 0;
	int         total_checks = 0;
	always #5 clk = ~clk;
	gsfm_mux DUT (
		.i_clk(clk), .i_resetn(resetn), .i_vpp_mode(vpp), .i_ctrl(ctrl), .i_dbg(dbg),
		.i_customer_clk(cclk), .i_pad_in(pin), .o_pad(pad), .o_port_read(prd),
		.o_led_drive_status(lst), .o_led_current_level(llev), .o_led_pulldown_disable(lpd),
		.o_xo_in(xo), .o_ref_clk(rck), .o_debug_clock_pin(dck), .o_debug_data_pin(ddat),
		.o_matrix_roff_pins(mrp), .o_matrix_roff(mr)
	);
	gsfm_far_model far (
		.i_clk(clk), .i_pad(pad), .i_btn_n(btn_n), .i_connect(conn), .i_override(ovr),
		.i_txn(txn), .i_dout(dout), .i_led_lit(lst), .o_pad_in(pin), .o_dbg(dbg)
	);
	// m is {vpp, customer clock, connect, override, transaction, debug data}
	task automatic go(input gsfm_ctrl_t v, input logic [9:0] b, input logic [5:0] m);
		@(posedge clk);
		ctrl <= v;
		btn_n <= b;
		{vpp, cclk, conn, ovr, txn, dout} <= m;
		repeat (3) @(posedge clk);
		#1;
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		c = '0;
		c.large_package = 1'b1;
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		// Plain pins
		c.port_drive_config = 10'h3_86;
		c.port_value = 10'h2_84;
		go(c, 10'h3_ff, 6'h00);
		`CHK(pad.oe & 10'h3_86, 10'h3_86)
		`CHK(prd & 10'h3_86, 10'h2_84)
		c.port_drive_config = 10'h0_00;
		go(c, 10'h3_ff, 6'h00);
		`CHK(pad.oe & 10'h3_86, 10'h1_02)
		c.large_package = 1'b0;
		go(c, 10'h3_ff, 6'h00);
		`CHK({prd[9:7], pad.oe[9:7]}, 6'h00)
		// Pin 0
		c.large_package = 1'b1;
		c.port_value = 10'h3_fe;
		c.port_drive_config = 10'h0_01;
		c.crystal_osc_enable = 1'b1;
		go(c, 10'h3_ff, 6'h00);
		`CHK({pad.oe[0], xo}, 2'b01)
		go(c, 10'h3_ff, 6'h20);
		`CHK(xo, 1'b0)
		c.crystal_osc_enable = 1'b0;
		go(c, 10'h3_ff, 6'h00);
		`CHK(xo, 1'b0)
		// Pin 3
		c.port_value = 10'h3_f7;
		c.port_drive_config = 10'h0_08;
		c.ref_clock_route_enable = 1'b1;
		go(c, 10'h3_ff, 6'h00);
		`CHK({pad.oe[3], rck}, 2'b01)
		c.ref_clock_route_enable = 1'b0;
		go(c, 10'h3_ff, 6'h00);
		`CHK({pad.oe[3], pad.out[3], rck}, 3'b100)
		// Customer clock on pins 4 and 6
		c.port_value = 10'h3_df;
		c.port_drive_config = 10'h0_00;
		c.clock_output_enable = 1'b1;
		for (int s = 0; s < 4; s++) begin
			c.clock_output_pin_select = 2'(s);
			go(c, 10'h3_ff, 6'h10);
			`CHK({pad.oe[6], pad.oe[4]}, 2'(s))
			`CHK({pad.out[6] & pad.oe[6], pad.out[4] & pad.oe[4]}, 2'(s))
		end
		go(c, 10'h3_ff, 6'h00);
		`CHK({pad.oe[6], pad.oe[4], pad.out[6], pad.out[4]}, 4'hc)
		c.clock_output_enable = 1'b0;
		go(c, 10'h3_ff, 6'h10);
		`CHK({pad.oe[6], pad.oe[4]}, 2'b00)
		c.clock_output_enable = 1'b1;
		go(c, 10'h3_ff, 6'h1a);
		`CHK({pad.oe[4], pad.out[4], pad.oe[6]}, 3'b101)
		go(c, 10'h3_ff, 6'h1b);
		`CHK({pad.oe[4], pad.out[4], ddat}, 3'b111)
		go(c, 10'h3_ff, 6'h18);
		`CHK({pad.oe[4], pad.out[4], ddat}, 3'b111)
		// LED driver
		c.clock_output_enable = 1'b0;
		c.port_value = 10'h3_ff;
		for (int l = 1; l < 4; l++) begin
			c.led_current_level = 2'(l);
			go(c, 10'h3_ff, 6'h00);
			`CHK({lst, llev, lpd, prd[5]}, {1'b1, 2'(l), 2'b11})
			`CHK({pad.oe[5], pad.out[5]}, 2'b11)
		end
		c.led_current_level = 2'h0;
		for (int b = 0; b < 2; b++) begin
			go(c, {4'hf, 1'(b), 5'h1f}, 6'h00);
			`CHK({lst, prd[5], pad.oe[5]}, 3'b000)
			`CHK(dck, 1'(b))
		end
		// Debug session
		c.port_value = 10'h3_df;
		go(c, 10'h3_ff, 6'h08);
		`CHK({pad.oe[5], pad.out[5]}, 2'b10)
		c.port_value = 10'h3_ff;
		c.led_current_level = 2'h2;
		go(c, 10'h3_ff, 6'h08);
		`CHK(lst, 1'b0)
		go(c, 10'h3_ff, 6'h0c);
		`CHK(lst, 1'b1)
		go(c, 10'h3_ff, 6'h00);
		`CHK(lst, 1'b1)
		go(c, 10'h3_ff, 6'h08);
		`CHK(lst, 1'b1)
		c.matrix_roff = 2'h2;
		go(c, 10'h3_ff, 6'h00);
		`CHK({mrp, mr}, 5'b11110)
		conclude();
	end
	initial begin
		#100_000;
		n_mismatch++;
		conclude();
	end
endmodule
